// >>> hdl/opd_regs.vh
// constants of the opcode page decoder
`ifndef OPD_REGS_VH
`define OPD_REGS_VH
// page escape prefix byte
`define OPD_PREFIX 8'h9e
// addressing mode codes
`define OPD_AM_IMPLIED 4'h0
`define OPD_AM_LITERAL 4'h1
`define OPD_AM_ZPAGE 4'h2
`define OPD_AM_FULL 4'h3
`define OPD_AM_BRANCH 4'h4
`define OPD_AM_IX0 4'h5
`define OPD_AM_IX8 4'h6
`define OPD_AM_IX16 4'h7
`define OPD_AM_SP8 4'h8
`define OPD_AM_SP16 4'h9
`define OPD_AM_IXPI 4'ha
`define OPD_AM_IX8PI 4'hb
`define OPD_AM_ZP_ZP 4'hc
`define OPD_AM_PI_ZP 4'hd
`define OPD_AM_LIT_ZP 4'he
`define OPD_AM_ZP_PI 4'hf
// operation class codes
`define OPD_OP_OTHER 4'h0
`define OPD_OP_SUB 4'h1
`define OPD_OP_NEG 4'h2
`define OPD_OP_COPY 4'h3
`define OPD_OP_ESC 4'h4
// timing figures of named instructions
`define OPD_NEG_SP8_BYTES 3'h3
`define OPD_NEG_SP8_CYC 4'h6
`define OPD_SUB_IX0_BYTES 3'h1
`define OPD_SUB_IX0_CYC 4'h3
`endif

// >>> hdl/opd_rom.v
// registered lookup of page-one and page-two opcode attributes
`include "opd_regs.vh"
module opd_rom
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_en,
  input wire i_page2,
  input wire [7:0] i_code,
  output reg [3:0] o_mode,
  output reg [3:0] o_op,
  output reg [2:0] o_bytes,
  output reg [3:0] o_cycles,
  output reg o_illegal
);
  reg [3:0] m;
  reg [3:0] op;
  reg [2:0] nb;
  reg [3:0] cy;
  reg bad;

  // --------------------------------------------------------------
  // attribute decode
  // --------------------------------------------------------------
  always @*
  begin
    m = `OPD_AM_IMPLIED;
    op = `OPD_OP_OTHER;
    nb = 3'h1;
    cy = 4'h1;
    bad = 1'b0;
    if (!i_page2)
    begin
      case (i_code[7:4])
        4'h0: begin m = `OPD_AM_ZPAGE; nb = 3'h3; cy = 4'h5; end
        4'h1: begin m = `OPD_AM_ZPAGE; nb = 3'h2; cy = 4'h5; end
        4'h2: begin m = `OPD_AM_BRANCH; nb = 3'h2; cy = 4'h3; end
        4'h3: begin m = `OPD_AM_ZPAGE; nb = 3'h2; cy = 4'h5; end
        4'h4: begin m = `OPD_AM_IMPLIED; nb = 3'h1; cy = 4'h1; end
        4'h5: begin m = `OPD_AM_IMPLIED; nb = 3'h1; cy = 4'h1; end
        4'h6: begin m = `OPD_AM_IX8; nb = 3'h2; cy = 4'h5; end
        4'h7: begin m = `OPD_AM_IX0; nb = 3'h1; cy = 4'h4; end
        4'h8, 4'h9: begin m = `OPD_AM_IMPLIED; nb = 3'h1; cy = 4'h2; end
        4'ha: begin m = `OPD_AM_LITERAL; nb = 3'h2; cy = 4'h2; end
        4'hb: begin m = `OPD_AM_ZPAGE; nb = 3'h2; cy = 4'h3; end
        4'hc: begin m = `OPD_AM_FULL; nb = 3'h3; cy = 4'h4; end
        4'hd: begin m = `OPD_AM_IX16; nb = 3'h3; cy = 4'h4; end
        4'he: begin m = `OPD_AM_IX8; nb = 3'h2; cy = 4'h3; end
        default: begin m = `OPD_AM_IX0; nb = 3'h1; cy = 4'h3; end
      endcase
      // per-code overrides: copy pairings, post-increment index, escape, subtract, full-address, illegal
      case (i_code)
        8'h4e: begin m = `OPD_AM_ZP_ZP; op = `OPD_OP_COPY; nb = 3'h3; cy = 4'h5; end
        8'h5e: begin m = `OPD_AM_ZP_PI; op = `OPD_OP_COPY; nb = 3'h2; cy = 4'h5; end
        8'h6e: begin m = `OPD_AM_LIT_ZP; op = `OPD_OP_COPY; nb = 3'h3; cy = 4'h4; end
        8'h7e: begin m = `OPD_AM_PI_ZP; op = `OPD_OP_COPY; nb = 3'h2; cy = 4'h5; end
        8'h71, 8'h61: m = (i_code[4]) ? `OPD_AM_IXPI : `OPD_AM_IX8PI;
        8'h9e: op = `OPD_OP_ESC;
        8'hf0: begin op = `OPD_OP_SUB; nb = `OPD_SUB_IX0_BYTES; cy = `OPD_SUB_IX0_CYC; end
        8'h32, 8'h3e: begin m = `OPD_AM_FULL; nb = 3'h3; cy = 4'h6; end
        8'h82, 8'h8d, 8'hac: bad = 1'b1;
        default: bad = 1'b0;
      endcase
      if (i_code[7:4] == 4'he || i_code[7:4] == 4'hf)
        if (i_code[3:0] == 4'h0)
          op = `OPD_OP_SUB;
    end
    else
    begin
      // second page: stack-relative forms, plus the a row in plain index mode
      case (i_code[7:4])
        4'h6: begin m = `OPD_AM_SP8; nb = 3'h3; cy = 4'h6;
          if (i_code[3:0] == 4'h0) op = `OPD_OP_NEG;
          if (i_code[3:0] == 4'h2 || i_code[3:0] == 4'h5 || i_code[3:0] == 4'he) bad = 1'b1;
        end
        4'hd: begin m = `OPD_AM_SP16; nb = 3'h4; cy = 4'h5;
          if (i_code[3:0] == 4'hc || i_code[3:0] == 4'hd) bad = 1'b1;
          if (i_code[3:0] == 4'h0) op = `OPD_OP_SUB;
        end
        4'he: begin m = `OPD_AM_SP8; nb = 3'h3; cy = 4'h4;
          if (i_code[3:0] == 4'hc || i_code[3:0] == 4'hd) bad = 1'b1;
          if (i_code[3:0] == 4'h0) op = `OPD_OP_SUB;
        end
        4'ha: begin m = `OPD_AM_IX0; nb = 3'h2; cy = 4'h5;
          if (i_code[3:0] != 4'he) bad = 1'b1;
        end
        4'hf: begin m = `OPD_AM_SP8; nb = 3'h3; cy = 4'h5;
          if (i_code[3:0] != 4'h3 && i_code[3:0] != 4'hf) bad = 1'b1;
        end
        default: bad = 1'b1;
      endcase
      if (i_code == 8'h60)
      begin
        nb = `OPD_NEG_SP8_BYTES;
        cy = `OPD_NEG_SP8_CYC;
      end
    end
  end

  // --------------------------------------------------------------
  // registered read data
  // --------------------------------------------------------------
  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_mode <= `OPD_AM_IMPLIED;
      o_op <= `OPD_OP_OTHER;
      o_bytes <= 3'h0;
      o_cycles <= 4'h0;
      o_illegal <= 1'b0;
    end
    else if (i_en)
    begin
      o_mode <= m;
      o_op <= op;
      o_bytes <= nb;
      o_cycles <= cy;
      o_illegal <= bad;
    end
  end
endmodule // opd_rom

// >>> hdl/opd_decoder.v
// opcode page decoder: byte stream in, instruction attributes out
// Operation
// - byte 9e is an escape; next byte decodes from page two.
// - page-two 60 is two's complement, stack 8-bit offset, 3 bytes, 6 cycles.
// - page-one f0 is subtract, plain index, 1 byte, 3 cycles.
// - stack pointer plus 8-bit or 16-bit offset modes exist.
// - post-increment index modes, no offset and one-byte offset.
// - branch mode plus index modes with 0, 8, 16-bit offsets.
// - implied, literal, zero-page and full-address modes are recognised.
// - byte copy has four memory-to-memory operand pairings.
`include "opd_regs.vh"
module opd_decoder
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_op_valid,
  input wire [7:0] i_op_byte,
  output wire o_op_ready,
  output reg o_dec_valid,
  output reg o_page2,
  output reg [7:0] o_opcode,
  output wire [3:0] o_mode,
  output wire [3:0] o_op_class,
  output wire [2:0] o_bytes,
  output wire [3:0] o_cycles,
  output wire o_illegal,
  output wire o_postinc,
  output wire o_stack_rel
);
  reg esc_r;
  wire take;
  wire is_esc;
  wire [3:0] rom_op;

  assign o_op_ready = 1'b1;
  assign take = i_op_valid;
  assign is_esc = !esc_r && (i_op_byte == `OPD_PREFIX);

  // --------------------------------------------------------------
  // page tracking
  // --------------------------------------------------------------
  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      esc_r <= 1'b0;
      o_page2 <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        esc_r <= is_esc;
        if (!is_esc)
          o_page2 <= esc_r;
      end
    end
  end

  // attribute lookup for page-one and page-two codes
  opd_rom u_rom
  (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_en(take && !is_esc),
    .i_page2(esc_r),
    .i_code(i_op_byte),
    .o_mode(o_mode),
    .o_op(rom_op),
    .o_bytes(o_bytes),
    .o_cycles(o_cycles),
    .o_illegal(o_illegal)
  );

  // --------------------------------------------------------------
  // outputs to the sequencer
  // --------------------------------------------------------------
  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_dec_valid <= 1'b0;
      o_opcode <= 8'h00;
    end
    else
    begin
      o_dec_valid <= take && !is_esc;
      if (take && !is_esc)
        o_opcode <= i_op_byte;
    end
  end

  assign o_op_class = rom_op;
  // index increment after use
  assign o_postinc = (o_mode == `OPD_AM_IXPI) || (o_mode == `OPD_AM_IX8PI)
    || (o_mode == `OPD_AM_PI_ZP) || (o_mode == `OPD_AM_ZP_PI);
  // stack pointer base
  assign o_stack_rel = (o_mode == `OPD_AM_SP8) || (o_mode == `OPD_AM_SP16);
endmodule // opd_decoder

// >>> tb/opd_props.sv
// assertions on the opcode page decoder ports
`include "opd_regs.vh"
module opd_props
(
  input logic i_core_clk,
  input logic i_rstn,
  input logic i_op_valid,
  input logic [7:0] i_op_byte,
  input logic o_dec_valid,
  input logic o_page2,
  input logic [7:0] o_opcode,
  input logic [3:0] o_mode,
  input logic [3:0] o_op_class,
  input logic [2:0] o_bytes,
  input logic [3:0] o_cycles,
  input logic o_illegal,
  input logic o_postinc,
  input logic o_stack_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_r;
  // -------------------------
  // prefix tracking and clocking
  // -------------------------
  always @(posedge i_core_clk)
    if (!i_rstn)
      pend_r <= 1'b0;
    else if (i_op_valid)
      pend_r <= !pend_r && i_op_byte == `OPD_PREFIX;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_prefix;
    i_op_valid && i_op_byte == `OPD_PREFIX && !pend_r;
  endsequence
  sequence s_code;
    i_op_valid && (pend_r || i_op_byte != `OPD_PREFIX);
  endsequence
  // -------------------------
  // properties
  // -------------------------
  chk_prefix_silent: assert property (s_prefix |=> !o_dec_valid)
    else $error("prefix answered");
  chk_prefix_page: assert property (s_prefix ##1 s_code |=> o_page2)
    else $error("page two lost");
  chk_code_answer: assert property (s_code |=> o_dec_valid &&
    o_opcode == $past(i_op_byte)) else $error("code not decoded");
  chk_idle_quiet: assert property (!i_op_valid |=> !o_dec_valid)
    else $error("decode without byte");
  chk_neg_stack: assert property (o_dec_valid && o_page2 &&
    o_opcode == 8'h60 |-> o_op_class == `OPD_OP_NEG && o_mode == `OPD_AM_SP8
    && o_bytes == 3'h3 && o_cycles == 4'h6) else $error("neg attrs");
  chk_sub_index: assert property (o_dec_valid && !o_page2 &&
    o_opcode == 8'hf0 |-> o_op_class == `OPD_OP_SUB && o_mode == `OPD_AM_IX0
    && o_bytes == 3'h1 && o_cycles == 4'h3) else $error("sub attrs");
  chk_stack_flag: assert property (o_dec_valid |-> o_stack_rel ==
    (o_page2 && (o_opcode[7:4] == 4'h6 || o_opcode[7:4] >= 4'hd)))
    else $error("stack");
  chk_postinc_flag: assert property (o_dec_valid && !o_page2 &&
    (o_opcode == 8'h61 || o_opcode == 8'h71 || o_opcode == 8'h5e
    || o_opcode == 8'h7e) |-> o_postinc) else $error("postinc flag");
  chk_copy_modes: assert property (o_dec_valid &&
    o_op_class == `OPD_OP_COPY |-> o_mode >= `OPD_AM_ZP_ZP)
    else $error("copy mode");
  chk_illegal_set: assert property (o_dec_valid && !o_page2 &&
    (o_opcode == 8'h82 || o_opcode == 8'h8d || o_opcode == 8'hac) |->
    o_illegal) else $error("illegal missed");
endmodule // opd_props

// >>> tb/opd_fetch_model.sv
// behavioural fetch unit feeding opcode bytes
module opd_fetch_model
(
  input logic i_core_clk,
  output logic o_op_valid = 1'b0,
  output logic [7:0] o_op_byte = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // one byte per cycle, launched at a falling edge
  task put(input logic [7:0] b);
    @(negedge i_core_clk);
    o_op_valid = 1'b1;
    o_op_byte = b;
  endtask
  // released byte line shows the inverse of its last value
  task idle();
    @(negedge i_core_clk);
    o_op_valid = 1'b0;
    o_op_byte = ~o_op_byte;
  endtask
endmodule // opd_fetch_model

// >>> tb/tb.sv
// testbench of the opcode page decoder
`include "opd_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_op_valid, o_op_ready, o_dec_valid, o_page2, o_illegal;
  logic o_postinc, o_stack_rel;
  logic [7:0] i_op_byte, o_opcode;
  logic [3:0] o_mode, o_op_class, o_cycles;
  logic [2:0] o_bytes;
  logic [25:0] dut_v;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  assign dut_v = {o_dec_valid, o_page2, o_opcode, o_mode, o_op_class,
    o_bytes, o_cycles, o_illegal};
  always #20 i_core_clk = ~i_core_clk;
  opd_fetch_model u_fetch (.i_core_clk, .o_op_valid(i_op_valid),
    .o_op_byte(i_op_byte));
  opd_decoder DUT (.i_core_clk, .i_rstn, .i_op_valid, .i_op_byte,
    .o_op_ready, .o_dec_valid, .o_page2, .o_opcode, .o_mode, .o_op_class,
    .o_bytes, .o_cycles, .o_illegal, .o_postinc, .o_stack_rel);
  // -------------------------
  // helpers
  // -------------------------
  task end_sim();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [25:0] g, e, m);
    n_tests++;
    if (((g ^ e) & m) !== 26'h0)
    begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task dec(input logic p2, input logic [7:0] op, input logic [25:0] e, m);
    if (p2)
      u_fetch.put(`OPD_PREFIX);
    u_fetch.put(op);
    u_fetch.idle();
    cmp(dut_v, e, m);
  endtask
  // -------------------------
  // scenarios
  // -------------------------
  task t_page2();
    u_fetch.put(`OPD_PREFIX);
    u_fetch.put(8'h60);
    cmp(dut_v, 26'h0, 26'h2000000);
    cmp({25'h0, o_op_ready}, 26'h1, 26'h1);
    u_fetch.idle();
    cmp(dut_v, {2'h3, 8'h60, `OPD_AM_SP8, `OPD_OP_NEG, `OPD_NEG_SP8_BYTES,
      `OPD_NEG_SP8_CYC, 1'b0}, 26'h3ffffff);
    cmp({25'h0, o_stack_rel}, 26'h1, 26'h1);
    dec(1'b1, 8'hd0, {2'h3, 8'hd0, `OPD_AM_SP16, 12'h0}, 26'h3fff001);
  endtask
  task t_sub();
    dec(1'b0, 8'hf0, {2'h2, 8'hf0, `OPD_AM_IX0, `OPD_OP_SUB,
      `OPD_SUB_IX0_BYTES, `OPD_SUB_IX0_CYC, 1'b0}, 26'h3ffffff);
    cmp({25'h0, o_stack_rel}, 26'h0, 26'h1);
  endtask
  // table ordered by mode code, implied through 16-bit index
  task t_modes();
    logic [7:0] ops [8] = '{8'h4c, 8'ha6, 8'hb6, 8'hc6, 8'h26, 8'hf6, 8'he6,
      8'hd6};
    for (int i = 0; i < 8; i++)
      dec(1'b0, ops[i], {2'h2, ops[i], 4'(i), 12'h0}, 26'h3fff001);
  endtask
  task t_copy();
    logic [3:0] md [4] = '{`OPD_AM_ZP_ZP, `OPD_AM_ZP_PI, `OPD_AM_LIT_ZP,
      `OPD_AM_PI_ZP};
    logic [7:0] op;
    for (int i = 0; i < 4; i++)
    begin
      op = 8'h4e + 8'(i * 16);
      dec(1'b0, op, {2'h2, op, md[i], `OPD_OP_COPY, 8'h0}, 26'h3ffff01);
      cmp({25'h0, o_postinc}, 26'(i % 2), 26'h1);
    end
    dec(1'b0, 8'h71, {2'h2, 8'h71, `OPD_AM_IXPI, 12'h0}, 26'h3fff001);
    cmp({25'h0, o_postinc}, 26'h1, 26'h1);
    dec(1'b0, 8'h61, {2'h2, 8'h61, `OPD_AM_IX8PI, 12'h0}, 26'h3fff001);
    cmp({25'h0, o_postinc}, 26'h1, 26'h1);
  endtask
  task t_illegal();
    logic [8:0] c [5] = '{9'h082, 9'h08d, 9'h0ac, 9'h100, 9'h19e};
    for (int i = 0; i < 5; i++)
      dec(c[i][8], c[i][7:0], {1'b1, c[i], 15'h0, 1'b1}, 26'h3ff0001);
  endtask
  // -------------------------
  // main sequence and hang guard
  // -------------------------
  initial
  begin
    repeat (12) @(negedge i_core_clk);
    i_rstn = 1'b1;
    cmp(dut_v, 26'h0, 26'h3ffffff);
    t_page2();
    t_sub();
    t_modes();
    t_copy();
    t_illegal();
    end_sim();
  end
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      end_sim();
    end
  end
endmodule // tb
bind opd_decoder opd_props u_props (.i_core_clk, .i_rstn, .i_op_valid,
  .i_op_byte, .o_dec_valid, .o_page2, .o_opcode, .o_mode, .o_op_class,
  .o_bytes, .o_cycles, .o_illegal, .o_postinc, .o_stack_rel);
